/* File: rtl/sbp_pwm.v */
// six-output pwm generator with toothed and buffer modes, dead time and apb registers
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "sbp_consts.vh"

module sbp_pwm #(
  parameter [7:0] TICK_DIV = `SBP_TICK_DIV,
  parameter       CNT_W    = 16,
  parameter       DT_W     = 10
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire [5:0]  pwm_out,
  output wire [5:0]  pwm_oe,
  output reg         period_match_irq
);
  localparam [7:0] TICK_LAST = TICK_DIV - 8'h01;

  reg  [`SBP_CTRL_W-1:0] ctrl_r;
  reg  [CNT_W-1:0]       period_compare_r;
  reg  [CNT_W-1:0]       period_compare_buffer_r;
  reg  [DT_W-1:0]        dead_time_value_r;
  reg  [5:0]             output_pattern_latch_r;
  reg  [3*CNT_W-1:0]     phase_compare_r;
  reg  [3*CNT_W-1:0]     phase_compare_buffer_r;
  reg  [35:0]            stage_pattern_r;
  reg  [35:0]            next_pattern_r;
  reg  [CNT_W-1:0]       pwm_base_counter_r;
  reg  [7:0]             div_cnt_r;
  reg  [2:0]             phase_ff_r;
  reg  [5:0]             toothed_out_r;
  reg  [5:0]             latch_nxt;
  reg  [31:0]            rdata_nxt;
  reg                    addr_ok;
  integer                n;

  wire                   counter_run               = ctrl_r[`SBP_CTRL_RUN];
  wire                   dead_time_en              = ctrl_r[`SBP_CTRL_DT_EN];
  wire                   direct_compare_write_en   = ctrl_r[`SBP_CTRL_DCWE];
  wire                   period_buffer_transfer_en = ctrl_r[`SBP_CTRL_PBTE];
  wire                   pwm_mode_sel              = ctrl_r[`SBP_CTRL_BUF_MODE];
  wire                   active_level_sel          = ctrl_r[`SBP_CTRL_ALV_HIGH];
  wire                   port_mode_control         = ctrl_r[`SBP_CTRL_PORT_EN];

  wire                   wr_en    = psel && penable && pwrite;
  wire                   rd_setup = psel && !penable && !pwrite;
  wire [7:0]             phase_off = paddr - `SBP_OFF_PHASE0;
  wire [7:0]             pbuf_off  = paddr - `SBP_OFF_PHASE_BUF0;
  wire [7:0]             stage_off = paddr - `SBP_OFF_STAGE0;
  wire [7:0]             next_off  = paddr - `SBP_OFF_NEXT0;
  wire                   phase_hit = (phase_off[7:4] == 4'h0) && (phase_off[3:2] != 2'b11);
  wire                   pbuf_hit  = (pbuf_off[7:4] == 4'h0) && (pbuf_off[3:2] != 2'b11);
  wire                   stage_hit = (stage_off[7:5] == 3'h0) && (stage_off[4:2] < 3'd6);
  wire                   next_hit  = (next_off[7:5] == 3'h0) && (next_off[4:2] < 3'd6);

  wire                   tick;
  wire                   period_match;
  wire [2:0]             dt_start;
  wire [2:0]             dt_busy;
  wire [2:0]             dt_under;

  // zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // ------------------------------------------------------------------
  // base counter and its tick divider
  // ------------------------------------------------------------------
  assign tick         = counter_run && (div_cnt_r == TICK_LAST);
  assign period_match = tick && (pwm_base_counter_r == period_compare_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 8'h00;
    end else if (!counter_run || tick) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_base_counter_r <= {CNT_W{1'b0}};
    end else if (!counter_run) begin
      pwm_base_counter_r <= {CNT_W{1'b0}};
    end else if (period_match) begin
      pwm_base_counter_r <= {CNT_W{1'b0}};
    end else if (tick) begin
      pwm_base_counter_r <= pwm_base_counter_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_match_irq <= 1'b0;
    end else begin
      period_match_irq <= period_match;
    end
  end

  // ------------------------------------------------------------------
  // control, period and dead-time registers
  // ------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r                  <= `SBP_RST_CTRL;
      period_compare_buffer_r <= `SBP_RST_PERIOD;
      dead_time_value_r       <= `SBP_RST_DEAD_TIME;
    end else if (wr_en) begin
      if (paddr == `SBP_OFF_CTRL)
        ctrl_r <= pwdata[`SBP_CTRL_W-1:0];
      if (paddr == `SBP_OFF_PERIOD_BUF)
        period_compare_buffer_r <= pwdata[CNT_W-1:0];
      if (paddr == `SBP_OFF_DEAD_TIME)
        dead_time_value_r <= pwdata[DT_W-1:0];
    end
  end

  // the hardware reload beats a software write landing on the same edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_compare_r <= `SBP_RST_PERIOD;
    end else if (period_match && period_buffer_transfer_en) begin
      period_compare_r <= period_compare_buffer_r;
    end else if (wr_en && (paddr == `SBP_OFF_PERIOD)) begin
      period_compare_r <= pwdata[CNT_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // per-phase compare, flip-flop and dead timer
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_phase
      wire [CNT_W-1:0] cmp     = phase_compare_r[g*CNT_W +: CNT_W];
      wire [CNT_W-1:0] cmp_buf = phase_compare_buffer_r[g*CNT_W +: CNT_W];
      wire             hit     = tick && (pwm_base_counter_r == cmp);
      reg              ff_nxt;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          phase_compare_buffer_r[g*CNT_W +: CNT_W] <= `SBP_RST_PHASE;
        end else if (wr_en && pbuf_hit && (pbuf_off[3:2] == g)) begin
          phase_compare_buffer_r[g*CNT_W +: CNT_W] <= pwdata[CNT_W-1:0];
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          phase_compare_r[g*CNT_W +: CNT_W] <= `SBP_RST_PHASE;
        end else if (period_match) begin
          phase_compare_r[g*CNT_W +: CNT_W] <= cmp_buf;
        end else if (wr_en && phase_hit) begin
          if (!direct_compare_write_en)
            phase_compare_r[g*CNT_W +: CNT_W] <= cmp_buf;
          else if (phase_off[3:2] == g)
            phase_compare_r[g*CNT_W +: CNT_W] <= pwdata[CNT_W-1:0];
        end
      end

      always @* begin
        ff_nxt = phase_ff_r[g];
        if (!counter_run)
          ff_nxt = 1'b0;
        else if (pwm_mode_sel) begin
          if (hit)
            ff_nxt = !phase_ff_r[g];
        end else if (hit)
          ff_nxt = 1'b0;
        else if (period_match)
          ff_nxt = 1'b1;
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          phase_ff_r[g] <= 1'b0;
        end else begin
          phase_ff_r[g] <= ff_nxt;
        end
      end

      // clearing run drops the flip-flops silently: no dead interval is started then
      assign dt_start[g] = counter_run && (ff_nxt != phase_ff_r[g]);

      sbp_dead_timer #(
        .W (DT_W)
      ) u_dead_timer (
        .pclk      (pclk),
        .presetn   (presetn),
        .en        (dead_time_en),
        .start     (dt_start[g]),
        .load_val  (dead_time_value_r),
        .busy      (dt_busy[g]),
        .underflow (dt_under[g])
      );

      // toothed mode: each side is active only once the dead interval has run out,
      // so a zero compare leaves tick width minus dead time, possibly nothing
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          toothed_out_r[2*g]   <= 1'b1;
          toothed_out_r[2*g+1] <= 1'b0;
        end else begin
          toothed_out_r[2*g]   <= active_level_sel ~^ (phase_ff_r[g] && !dt_busy[g]);
          toothed_out_r[2*g+1] <= active_level_sel ~^ (!phase_ff_r[g] && !dt_busy[g]);
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // pattern registers
  // ------------------------------------------------------------------
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_pattern
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          next_pattern_r[6*g +: 6] <= `SBP_RST_PATTERN;
        end else if (wr_en && next_hit && (next_off[4:2] == g)) begin
          next_pattern_r[6*g +: 6] <= pwdata[5:0];
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage_pattern_r[6*g +: 6] <= `SBP_RST_PATTERN;
        end else if (period_match) begin
          stage_pattern_r[6*g +: 6] <= next_pattern_r[6*g +: 6];
        end else if (wr_en && stage_hit && (stage_off[4:2] == g)) begin
          stage_pattern_r[6*g +: 6] <= pwdata[5:0];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // output latch: later assignments win, so walk from lowest priority up;
  // a software write yields to any hardware transfer on the same edge
  // ------------------------------------------------------------------
  always @* begin
    latch_nxt = output_pattern_latch_r;
    if (wr_en && (paddr == `SBP_OFF_OUT_LATCH))
      latch_nxt = pwdata[5:0];
    for (n = 2; n >= 0; n = n - 1) begin
      if (dt_start[n])
        latch_nxt = stage_pattern_r[12*n +: 6];
      if (dt_under[n])
        latch_nxt = stage_pattern_r[12*n+6 +: 6];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_pattern_latch_r <= `SBP_RST_LATCH;
    end else if (pwm_mode_sel) begin
      output_pattern_latch_r <= latch_nxt;
    end else if (wr_en && (paddr == `SBP_OFF_OUT_LATCH)) begin
      output_pattern_latch_r <= pwdata[5:0];
    end
  end

  // buffer mode shows the latch as is, with no polarity applied
  assign pwm_out = pwm_mode_sel ? output_pattern_latch_r : toothed_out_r;
  assign pwm_oe  = {6{port_mode_control}};

  // ------------------------------------------------------------------
  // apb read path: data captured in the setup cycle, valid in access
  // ------------------------------------------------------------------
  always @* begin
    rdata_nxt = 32'h0000_0000;
    addr_ok   = 1'b1;
    if (paddr[1:0] != 2'b00)
      addr_ok = 1'b0;
    else if (paddr == `SBP_OFF_CTRL)
      rdata_nxt[`SBP_CTRL_W-1:0] = ctrl_r;
    else if (paddr == `SBP_OFF_PERIOD)
      rdata_nxt[CNT_W-1:0] = period_compare_r;
    else if (paddr == `SBP_OFF_PERIOD_BUF)
      rdata_nxt[CNT_W-1:0] = period_compare_buffer_r;
    else if (paddr == `SBP_OFF_DEAD_TIME)
      rdata_nxt[DT_W-1:0] = dead_time_value_r;
    else if (paddr == `SBP_OFF_OUT_LATCH)
      rdata_nxt = 32'h0000_0000; // write-only, reads as zero
    else if (paddr == `SBP_OFF_STATUS) begin
      rdata_nxt[`SBP_STAT_CNT_LSB +: CNT_W] = pwm_base_counter_r;
      rdata_nxt[`SBP_STAT_FF_LSB +: 3]      = phase_ff_r;
      rdata_nxt[`SBP_STAT_BUSY_LSB +: 3]    = dt_busy;
      rdata_nxt[`SBP_STAT_RUN]              = counter_run;
    end else if (phase_hit)
      rdata_nxt[CNT_W-1:0] = phase_compare_r[phase_off[3:2]*CNT_W +: CNT_W];
    else if (pbuf_hit)
      rdata_nxt[CNT_W-1:0] = phase_compare_buffer_r[pbuf_off[3:2]*CNT_W +: CNT_W];
    else if (stage_hit)
      rdata_nxt[5:0] = stage_pattern_r[stage_off[4:2]*6 +: 6];
    else if (next_hit)
      rdata_nxt[5:0] = next_pattern_r[next_off[4:2]*6 +: 6];
    else
      addr_ok = 1'b0;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    // status shows the counter as it stood in the setup cycle
    end else if (rd_setup) begin
      prdata <= rdata_nxt;
    end
  end

endmodule // sbp_pwm

/* File: rtl/sbp_consts.vh */
// register map, control bit positions and reset values of the buffered six-channel pwm
`ifndef SBP_CONSTS_VH
`define SBP_CONSTS_VH

// byte offsets on the apb bus
`define SBP_OFF_CTRL        8'h00
`define SBP_OFF_PERIOD      8'h04
`define SBP_OFF_PERIOD_BUF  8'h08
`define SBP_OFF_DEAD_TIME   8'h0c
`define SBP_OFF_OUT_LATCH   8'h10
`define SBP_OFF_STATUS      8'h14
`define SBP_OFF_PHASE0      8'h20
`define SBP_OFF_PHASE_BUF0  8'h30
`define SBP_OFF_STAGE0      8'h40
`define SBP_OFF_NEXT0       8'h60

// control register bit positions
`define SBP_CTRL_RUN        0
`define SBP_CTRL_DT_EN      1
`define SBP_CTRL_DCWE       2
`define SBP_CTRL_PBTE       3
`define SBP_CTRL_BUF_MODE   4
`define SBP_CTRL_ALV_HIGH   5
`define SBP_CTRL_PORT_EN    6
`define SBP_CTRL_W          7

// status register field positions
`define SBP_STAT_CNT_LSB    0
`define SBP_STAT_FF_LSB     16
`define SBP_STAT_BUSY_LSB   19
`define SBP_STAT_RUN        24

// reset values
`define SBP_RST_CTRL        7'h00
`define SBP_RST_PERIOD      16'hffff
`define SBP_RST_PHASE       16'hffff
`define SBP_RST_DEAD_TIME   10'h000
`define SBP_RST_PATTERN     6'h00
`define SBP_RST_LATCH       6'h15
`define SBP_DT_STOP         10'h3ff

// timing: base counter tick divider default, in system clocks per tick
`define SBP_TICK_DIV        8'h01

`endif

/* File: rtl/sbp_dead_timer.v */
// one dead-time down counter with start and underflow events
`timescale 1ns/100ps
module sbp_dead_timer #(
  parameter W = 10
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         en,
  input  wire         start,
  input  wire [W-1:0] load_val,
  output wire         busy,
  output wire         underflow
);
  localparam [W-1:0] STOP = {W{1'b1}};

  reg  [W-1:0] cnt_r;

  // counter runs load_val..0 then wraps to all ones: load_val+1 clocks busy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= STOP;
    end else if (!en) begin
      cnt_r <= STOP;
    end else if (start) begin
      cnt_r <= load_val;
    end else if (cnt_r != STOP) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign busy = (cnt_r != STOP);
  // with insertion off the interval collapses: underflow coincides with start
  assign underflow = en ? ((cnt_r == {W{1'b0}}) && !start) : start;

endmodule // sbp_dead_timer

/* File: tb/sbp_pwm_properties.sv */
// assertion checker for the buffered six-channel pwm, bound to its top module
`timescale 1ns/100ps
module sbp_pwm_props #(
  parameter [7:0] TICK_DIV = 8'h01,
  parameter       CNT_W    = 16,
  parameter       DT_W     = 10
) (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [5:0]  pwm_out,
  input logic [5:0]  pwm_oe,
  input logic        period_match_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [6:0]  ctrl_r;
  logic [10:0] quiet_r;
  logic [5:0]  lw_r;
  logic        lw_v_r;
  wire         acc = psel && penable;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 7'h00;
      quiet_r <= 11'h000;
      lw_r <= 6'h00;
      lw_v_r <= 1'b0;
    end else begin
      if (acc && pwrite && paddr == 8'h00)
        ctrl_r <= pwdata[6:0];
      // dead timers may still move the latch up to 1024 clocks after run clears
      if (ctrl_r[0])
        quiet_r <= 11'h44c;
      else if (quiet_r != 11'h000)
        quiet_r <= quiet_r - 11'h001;
      lw_v_r <= acc && pwrite && paddr == 8'h10;
      lw_r <= pwdata[5:0];
    end
  end
  property p_irq_pulse; period_match_irq |=> !period_match_irq; endproperty
  property p_irq_idle; !ctrl_r[0] && !$past(ctrl_r[0]) |-> !period_match_irq; endproperty
  property p_oe_follow; pwm_oe == {6{ctrl_r[6]}}; endproperty
  property p_rst_pins; $rose(presetn) |-> pwm_out == 6'h15 && pwm_oe == 6'h00; endproperty
  property p_latch_wr; lw_v_r && ctrl_r[4] && quiet_r == 11'h000 |-> pwm_out == lw_r; endproperty
  property p_latch_rd0; acc && !pwrite && paddr == 8'h10 |-> prdata == 32'h0; endproperty
  property p_pat_upper;
    acc && !pwrite && paddr[7:6] == 2'b01 && paddr[4:0] < 5'h18 |-> prdata[31:6] == 26'h0;
  endproperty
  property p_slverr; acc && !pwrite && paddr == 8'h18 |-> pslverr && prdata == 32'h0; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("period pulse too long");
  a_irq_idle: assert property (p_irq_idle) else $error("period pulse while stopped");
  a_oe_follow: assert property (p_oe_follow) else $error("pin drive mismatch");
  a_rst_pins: assert property (p_rst_pins) else $error("pins wrong after reset");
  a_latch_wr: assert property (p_latch_wr) else $error("latch write not on pins");
  a_latch_rd0: assert property (p_latch_rd0) else $error("latch readable");
  a_pat_upper: assert property (p_pat_upper) else $error("pattern upper bits set");
  a_slverr: assert property (p_slverr) else $error("unmapped read accepted");
  c_irq: cover property (period_match_irq);
  c_latch: cover property (lw_v_r && ctrl_r[4]);
  c_err: cover property (acc && pslverr);
endmodule // sbp_pwm_props

bind sbp_pwm sbp_pwm_props #(.TICK_DIV(TICK_DIV), .CNT_W(CNT_W), .DT_W(DT_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwm_out(pwm_out), .pwm_oe(pwm_oe), .period_match_irq(period_match_irq));

/* File: tb/sbp_gate_drv.sv */
// gate driver model of the inverter stage fed by the six pwm pins
`timescale 1ns/100ps
module sbp_gate_drv (
  input  logic [5:0] pwm_out,
  input  logic [5:0] pwm_oe,
  output logic [5:0] gate
);
  // driver inputs carry pull-downs, so a released pin reads low, not its last level
  assign gate = pwm_out & pwm_oe;
endmodule // sbp_gate_drv

/* File: tb/tb_six_channel_buffered_pwm.sv */
// self-checking bench for the buffered six-channel pwm: apb tasks and pin scenarios
`timescale 1ns/100ps
`include "sbp_consts.vh"
module tb_six_channel_buffered_pwm;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [5:0]  pwm_out;
  wire  [5:0]  pwm_oe;
  wire  [5:0]  gate;
  wire         period_match_irq;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n;
  logic [31:0] q;
  logic        err;
  logic [5:0]  v;
  logic [7:0]  pat [6] = '{8'h0c, 8'h30, 8'h03, 8'h21, 8'h0a, 8'h05};

  always #4 pclk = ~pclk;

  sbp_pwm dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .period_match_irq(period_match_irq));
  sbp_gate_drv u_gate (.pwm_out(pwm_out), .pwm_oe(pwm_oe), .gate(gate));

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // setup after an idle edge, hold until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(q, e, m);
    chk(32'(err), 32'h0, "slave error");
  endtask

  task automatic wait_pin(input logic [5:0] t, input logic eq);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while ((pwm_out === t) !== eq && n < 300);
    v = pwm_out;
    if (n >= 300)
      chk(32'(n), 32'd0, "pin wait limit");
  endtask

  task automatic wait_irq;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (period_match_irq !== 1'b1 && n < 300);
    if (n >= 300)
      chk(32'(n), 32'd0, "irq wait limit");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(32'(pwm_out), 32'h15, "idle pattern");
    chk(32'(gate), 32'h0, "pins released");
    rd(`SBP_OFF_PERIOD, 32'hffff, "period reset");
    rd(`SBP_OFF_NEXT0, 32'h0, "next reset");
    rd(`SBP_OFF_STATUS, 32'h0, "status idle");
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(err), 32'h1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    wr(`SBP_OFF_CTRL, 32'h50);
    #1;
    chk(32'(gate), 32'h15, "control mode");
    wr(`SBP_OFF_OUT_LATCH, 32'h2a);
    #1;
    chk(32'(gate), 32'h2a, "latch write");
    rd(`SBP_OFF_OUT_LATCH, 32'h0, "latch read");
    wr(`SBP_OFF_STAGE0, 32'hff);
    rd(`SBP_OFF_STAGE0, 32'h3f, "upper bits");
    $display("test 1 done");
    wr(`SBP_OFF_CTRL, 32'h54);
    wr(`SBP_OFF_PHASE0, 32'h5);
    rd(`SBP_OFF_PHASE0, 32'h5, "direct write");
    wr(`SBP_OFF_PHASE_BUF0, 32'h2);
    wr(`SBP_OFF_PHASE_BUF0 + 8'h04, 32'h2);
    wr(`SBP_OFF_CTRL, 32'h50);
    for (int i = 0; i < 3; i++)
      wr(8'(`SBP_OFF_PHASE0 + 4 * i), 32'h99);
    rd(`SBP_OFF_PHASE0, 32'h2, "buffer copy 0");
    rd(`SBP_OFF_PHASE0 + 8'h04, 32'h2, "buffer copy 1");
    $display("test 2 done");
    wr(`SBP_OFF_PERIOD, 32'h9);
    rd(`SBP_OFF_PERIOD, 32'h9, "period direct");
    for (int i = 0; i < 6; i++) begin
      wr(8'(`SBP_OFF_STAGE0 + 4 * i), {24'h0, pat[i]});
      wr(8'(`SBP_OFF_NEXT0 + 4 * i), {24'h0, pat[i]});
    end
    wr(`SBP_OFF_DEAD_TIME, 32'h3);
    wr(`SBP_OFF_OUT_LATCH, 32'h0);
    wr(`SBP_OFF_CTRL, 32'h73);
    wait_pin(6'h0c, 1'b1);
    chk(32'(pwm_out), 32'h0c, "pair start");
    wait_pin(6'h30, 1'b1);
    chk(32'(n), 32'd4, "dead interval");
    wait_irq;
    wait_irq;
    chk(32'(n), 32'd10, "period length");
    $display("test 3 done");
    wr(`SBP_OFF_PERIOD_BUF, 32'h6);
    wr(`SBP_OFF_PHASE_BUF0 + 8'h08, 32'h1);
    wr(`SBP_OFF_NEXT0, 32'h11);
    wr(`SBP_OFF_CTRL, 32'h7f);
    wait_irq;
    rd(`SBP_OFF_PERIOD, 32'h6, "period reload");
    rd(`SBP_OFF_PHASE0 + 8'h08, 32'h1, "phase reload");
    rd(`SBP_OFF_STAGE0, 32'h11, "pattern reload");
    wait_irq;
    wait_irq;
    chk(32'(n), 32'd7, "new period");
    $display("test 4 done");
    wr(`SBP_OFF_PHASE_BUF0 + 8'h08, 32'hffff);
    wr(`SBP_OFF_CTRL, 32'h7d);
    wait_irq;
    wait_irq;
    wait_pin(6'h30, 1'b1);
    wr(`SBP_OFF_OUT_LATCH, 32'h0);
    wait_pin(6'h00, 1'b0);
    chk(32'(v), 32'h30, "no dead time");
    wr(`SBP_OFF_CTRL, 32'h50);
    $display("test 5 done");
    wr(`SBP_OFF_PHASE_BUF0, 32'h0);
    wr(`SBP_OFF_PHASE_BUF0 + 8'h04, 32'h6);
    wr(`SBP_OFF_PHASE_BUF0 + 8'h08, 32'h5);
    wr(`SBP_OFF_PHASE0, 32'h0);
    wr(`SBP_OFF_CTRL, 32'h63);
    v = 6'h00;
    q = 32'hffff_ffff;
    repeat (30) begin
      @(posedge pclk);
      #1;
      v = v | pwm_out;
      q = q & 32'(pwm_out);
    end
    chk(32'(v[0]), 32'h0, "zero compare pulse");
    chk(32'(v[2]), 32'h0, "set after reset");
    chk(32'(q[3]), 32'h1, "negative phase held");
    chk(32'(v[4]), 32'h1, "toothed pulse");
    wr(`SBP_OFF_CTRL, 32'h0);
    $display("test 6 done");
    complete_run;
  end
endmodule // tb_six_channel_buffered_pwm
